// file: logic/cpc_pkg.sv
package cpc_pkg;

    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    localparam logic [7:0] CPC_OFS_CONTROL = 8'h00;
    localparam logic [7:0] CPC_OFS_STATUS = 8'h01;
    localparam logic [7:0] CPC_OFS_SAFETY_LIMIT = 8'h06;

    // Control register fields
    localparam int CPC_CTL_STAT_EN = 0;
    localparam int CPC_CTL_BOOST_PIN_EN = 1;
    localparam int CPC_CTL_SOFT_BOOST = 2;
    localparam int CPC_CTL_ILIM_LO = 3;
    localparam int CPC_CTL_ILIM_HI = 4;
    localparam logic [7:0] CPC_CONTROL_RST = 8'h03;

    // Status register fields
    localparam int CPC_STS_STAT_DRIVE = 0;
    localparam int CPC_STS_PULSE = 1;
    localparam int CPC_STS_BOOST = 2;
    localparam int CPC_STS_STARTUP = 3;
    localparam int CPC_STS_LOCKED = 4;
    localparam int CPC_STS_CHARGE_EN = 5;

    // Safety limit default after reset or while the limit reset pin is low
    localparam logic [7:0] CPC_SAFETY_LIMIT_RST = 8'h00;

    // -----------------------------------------------------------------
    // Input current limit codes
    // -----------------------------------------------------------------
    localparam logic [1:0] CPC_ILIM_100MA = 2'h0;
    localparam logic [1:0] CPC_ILIM_500MA = 2'h1;

    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int CPC_CLK_HZ = 20000000;
    localparam int CPC_FAULT_PULSE_US = 128;
    // Exact: 128 us at 20 MHz is a whole number of cycles
    localparam int CPC_FAULT_PULSE_CYC = (CPC_FAULT_PULSE_US * (CPC_CLK_HZ / 1000000));

endpackage

// file: logic/cpc_pulse_if.sv
`timescale 1ns/100ps

// Carries the fault pulse request and its running state between modules
interface cpc_pulse_if;
    logic fire;
    logic busy;

    modport timer (
        input fire,
        output busy
    );

    modport user (
        output fire,
        input busy
    );
endinterface

// file: logic/cpc_pulse_timer.sv
`timescale 1ns/100ps

module cpc_pulse_timer #(
    parameter int PULSE_CYC = cpc_pkg::CPC_FAULT_PULSE_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Pulse request and state
    cpc_pulse_if.timer pulse
);
    import cpc_pkg::*;

    localparam int CW = $clog2(PULSE_CYC + 1);

    // -----------------------------------------------------------------
    // Elaboration check
    // -----------------------------------------------------------------
    if (PULSE_CYC < 1) begin : g_chk
        $error("cpc_pulse_timer: PULSE_CYC must be at least 1");
    end

    typedef struct packed {
        logic busy;
        logic [CW-1:0] count;
    } cpc_tmr_s;

    cpc_tmr_s state_r;
    cpc_tmr_s state_nxt;

    // One pulse of fixed length; a request while busy is ignored
    always_comb begin
        state_nxt = state_r;
        if (state_r.busy) begin
            if (state_r.count == CW'(PULSE_CYC - 1)) begin
                state_nxt.busy = 1'b0;
                state_nxt.count = '0;
            end else begin
                state_nxt.count = state_r.count + CW'(1);
            end
        end else if (pulse.fire) begin
            state_nxt.busy = 1'b1;
            state_nxt.count = '0;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign pulse.busy = state_r.busy;

endmodule // cpc_pulse_timer

// file: logic/cpc_charger_pin_ctl.sv
`timescale 1ns/100ps

module cpc_charger_pin_ctl #(
    parameter int PULSE_CYC = cpc_pkg::CPC_FAULT_PULSE_CYC,
    parameter logic [7:0] SAFETY_DEFAULT = cpc_pkg::CPC_SAFETY_LIMIT_RST
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Register access port (decoded serial interface)
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // Control pins
    input wire logic charge_inhibit_pin,
    input wire logic boost_request_pin,
    input wire logic limit_reset_pin,
    // Charger core status
    input wire logic chargeActive,
    input wire logic faultEvent,
    // Status pin, open drain
    output logic statOut,
    output logic statOe,
    // Charger core control
    output logic chargeEnable,
    output logic vbusHighZ,
    output logic boostMode,
    output logic [1:0] inputLimitCode,
    output logic [7:0] safetyLimit
);
    import cpc_pkg::*;

    // -----------------------------------------------------------------
    // Elaboration check
    // -----------------------------------------------------------------
    if (PULSE_CYC < 1) begin : g_chk
        $error("cpc_charger_pin_ctl: PULSE_CYC must be at least 1");
    end

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] control;
        logic [7:0] safety;
        logic locked;
        logic startup;
        logic faultPrev;
        logic statDrive;
        logic boost;
        logic chargeEn;
        logic [1:0] ilim;
        logic [7:0] rdData;
    } cpc_top_s;

    cpc_top_s state_r;
    cpc_top_s state_nxt;

    cpc_pulse_if pulseBus ();

    // Fault pulse generator
    cpc_pulse_timer #(
        .PULSE_CYC(PULSE_CYC)
    ) u_pulse (
        .mclk(mclk),
        .rstn(rstn),
        .pulse(pulseBus.timer)
    );

    // Offset decode, used for writes and reads alike
    function automatic logic isAddr(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // Pin-selected input limit used while in startup mode
    function automatic logic [1:0] pinLimit(input logic pin);
        return pin ? CPC_ILIM_500MA : CPC_ILIM_100MA;
    endfunction

    logic statEn;
    logic boostPinEn;
    logic boostPinActive;
    logic [7:0] statusWord;

    // Both enable bits reset set; the status pin works before the host writes anything, the boost pin only once startup ends
    assign statEn = state_r.control[CPC_CTL_STAT_EN];
    assign boostPinEn = state_r.control[CPC_CTL_BOOST_PIN_EN];
    // The pin is a current select in startup, so it cannot request boost then
    assign boostPinActive = boost_request_pin && boostPinEn && !state_r.startup;

    // Fault edge starts one pulse; the timer ignores edges while busy
    assign pulseBus.fire = faultEvent && !state_r.faultPrev && statEn;

    // Status word built from live state
    always_comb begin
        statusWord = 8'h00;
        statusWord[CPC_STS_STAT_DRIVE] = state_r.statDrive;
        statusWord[CPC_STS_PULSE] = pulseBus.busy;
        statusWord[CPC_STS_BOOST] = state_r.boost;
        statusWord[CPC_STS_STARTUP] = state_r.startup;
        statusWord[CPC_STS_LOCKED] = state_r.locked;
        statusWord[CPC_STS_CHARGE_EN] = state_r.chargeEn;
    end

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        // Edge detector idles low like the fault input, so reset gives no false edge
        state_nxt.faultPrev = faultEvent;

        // Register writes; any write ends startup mode, and only a reset
        // brings it back, since the pin current select is a power-on behaviour
        if (regWrEn) begin
            state_nxt.startup = 1'b0;
            if (isAddr(regAddr, CPC_OFS_CONTROL)) begin
                state_nxt.control = regWrData;
            end
            if (isAddr(regAddr, CPC_OFS_SAFETY_LIMIT)) begin
                if (limit_reset_pin && !state_r.locked) begin
                    state_nxt.safety = regWrData;
                end
            end else if (limit_reset_pin) begin
                // Any other offset freezes the limits, so a host must set them
                // first; a write while the pin is low leaves them unlocked
                state_nxt.locked = 1'b1;
            end
        end

        // Pin low overrides the limit logic: default limits, limit writes dropped, unlocked
        if (!limit_reset_pin) begin
            state_nxt.safety = SAFETY_DEFAULT;
            state_nxt.locked = 1'b0;
        end

        // Status pin: low while charging or pulsing, silent when disabled.
        // Clearing the enable mid-pulse hides the rest of the pulse at once.
        state_nxt.statDrive = statEn && (chargeActive || pulseBus.busy);

        // Charge gating from the inhibit pin
        state_nxt.chargeEn = !charge_inhibit_pin;

        // Pin request wins over the software bit when honoured
        if (boostPinActive) begin
            state_nxt.boost = 1'b1;
        end else begin
            state_nxt.boost = state_r.control[CPC_CTL_SOFT_BOOST];
        end

        // Software limit is ignored until startup ends
        if (state_r.startup) begin
            state_nxt.ilim = pinLimit(boost_request_pin);
        end else begin
            state_nxt.ilim = state_r.control[CPC_CTL_ILIM_HI:CPC_CTL_ILIM_LO];
        end

        // Registered read data; unmapped offsets read zero
        if (regRdEn) begin
            if (isAddr(regAddr, CPC_OFS_CONTROL)) begin
                state_nxt.rdData = state_r.control;
            end else if (isAddr(regAddr, CPC_OFS_STATUS)) begin
                state_nxt.rdData = statusWord;
            end else if (isAddr(regAddr, CPC_OFS_SAFETY_LIMIT)) begin
                state_nxt.rdData = state_r.safety;
            end else begin
                state_nxt.rdData = 8'h00;
            end
        end
    end

    // -----------------------------------------------------------------
    // State register
    // -----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_r.control <= CPC_CONTROL_RST;
            state_r.safety <= SAFETY_DEFAULT;
            state_r.locked <= 1'b0;
            state_r.startup <= 1'b1;
            state_r.faultPrev <= 1'b0;
            state_r.statDrive <= 1'b0;
            state_r.boost <= 1'b0;
            state_r.chargeEn <= 1'b0;
            state_r.ilim <= CPC_ILIM_100MA;
            state_r.rdData <= 8'h00;
        end else begin
            state_r <= state_nxt;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    // Open drain: only ever drives low, released otherwise
    assign statOut = 1'b0;
    assign statOe = state_r.statDrive;
    assign chargeEnable = state_r.chargeEn;
    // Input side floats exactly while charging is inhibited
    assign vbusHighZ = !state_r.chargeEn;
    assign boostMode = state_r.boost;
    assign inputLimitCode = state_r.ilim;
    assign safetyLimit = state_r.safety;
    // Read data stays until the next read strobe
    assign regRdData = state_r.rdData;

endmodule // cpc_charger_pin_ctl

// file: testbench/cpc_pin_props.sv
`timescale 1ns/100ps

module cpc_pin_props #(
    parameter int PULSE_CYC = cpc_pkg::CPC_FAULT_PULSE_CYC,
    parameter logic [7:0] SAFETY_DEFAULT = 8'h00
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Register port
    input wire logic regWrEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    // Pins and core status
    input wire logic charge_inhibit_pin,
    input wire logic boost_request_pin,
    input wire logic limit_reset_pin,
    input wire logic chargeActive,
    // Outputs watched
    input wire logic statOut,
    input wire logic statOe,
    input wire logic chargeEnable,
    input wire logic vbusHighZ,
    input wire logic boostMode,
    input wire logic [1:0] inputLimitCode,
    input wire logic [7:0] safetyLimit
);
    import cpc_pkg::*;

    typedef struct packed {
        logic en;
        logic wr;
        logic lk;
        logic ca;
        logic [11:0] cnt;
    } cpc_chk_s;
    cpc_chk_s st_r;
    cpc_chk_s st_nxt;

    // Shadow of stat enable, startup end, lock and the length of a bare pulse
    always_comb begin
        st_nxt = st_r;
        st_nxt.ca = chargeActive;
        st_nxt.wr = st_r.wr | regWrEn;
        if (regWrEn && regAddr == CPC_OFS_CONTROL) begin
            st_nxt.en = regWrData[CPC_CTL_STAT_EN];
        end
        if (regWrEn && regAddr != CPC_OFS_SAFETY_LIMIT) begin
            st_nxt.lk = 1'b1;
        end
        // Pin low wins over a write in the same cycle
        if (!limit_reset_pin) begin
            st_nxt.lk = 1'b0;
        end
        st_nxt.cnt = (statOe && !st_r.ca && !chargeActive) ? st_r.cnt + 12'h001 : 12'h000;
    end

    // Helper state register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '{en: CPC_CONTROL_RST[CPC_CTL_STAT_EN], default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence s_safe_wr;
        limit_reset_pin && regWrEn && regAddr == CPC_OFS_SAFETY_LIMIT;
    endsequence
    sequence s_start;
        !st_r.wr && !regWrEn;
    endsequence

    a_stat_drive: assert property (st_r.en && chargeActive |=> statOe && !statOut)
        else $error("status pin not pulled low while charging");
    a_pulse_len: assert property (st_r.cnt <= PULSE_CYC)
        else $error("status pin held low too long");
    a_stat_off: assert property (!st_r.en |=> !statOe)
        else $error("status pin active while disabled");
    a_inhibit_stop: assert property (
        charge_inhibit_pin |=> !chargeEnable && vbusHighZ)
        else $error("charging not stopped");
    a_inhibit_go: assert property (
        !charge_inhibit_pin |=> chargeEnable && !vbusHighZ)
        else $error("charging not allowed");
    a_startup_limit: assert property (
        s_start |=> !boostMode && inputLimitCode ==
        ($past(boost_request_pin) ? CPC_ILIM_500MA : CPC_ILIM_100MA))
        else $error("startup current limit wrong");
    a_limit_hold: assert property (
        !limit_reset_pin |=> safetyLimit == SAFETY_DEFAULT)
        else $error("safety limit not held at default");
    a_limit_write: assert property (
        s_safe_wr ##0 !st_r.lk |=> safetyLimit == $past(regWrData))
        else $error("safety limit write lost");
    a_limit_lock: assert property (s_safe_wr ##0 st_r.lk |=> $stable(safetyLimit))
        else $error("locked safety limit changed");
endmodule // cpc_pin_props

bind cpc_charger_pin_ctl cpc_pin_props #(
    .PULSE_CYC(PULSE_CYC), .SAFETY_DEFAULT(SAFETY_DEFAULT)) chk (
    .mclk(mclk), .rstn(rstn), .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
    .charge_inhibit_pin(charge_inhibit_pin), .boost_request_pin(boost_request_pin),
    .limit_reset_pin(limit_reset_pin), .chargeActive(chargeActive), .statOut(statOut),
    .statOe(statOe), .chargeEnable(chargeEnable), .vbusHighZ(vbusHighZ), .boostMode(boostMode),
    .inputLimitCode(inputLimitCode), .safetyLimit(safetyLimit));

// file: testbench/cpc_host_model.sv
`timescale 1ns/100ps

module cpc_host_model (
    // Clock
    input wire logic mclk,
    // Register port toward the block
    output logic regWrEn,
    output logic regRdEn,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    input wire logic [7:0] regRdData
);
    // Idle port
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
    end

    // One-cycle strobe; idle lines are scrambled so no stale value helps
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(posedge mclk);
        #1;
        regWrEn = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask

    // Read data is taken one edge after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        #1;
        regRdEn = 1'b1;
        regAddr = a;
        @(posedge mclk);
        #1;
        regRdEn = 1'b0;
        regAddr = ~a;
        @(posedge mclk);
        #1;
        d = regRdData;
    endtask
endmodule // cpc_host_model

// file: testbench/testbench.sv
`timescale 1ns/100ps

module testbench;
    import cpc_pkg::*;
    localparam int PULSE = 8;
    logic mclk, rstn, regWrEn, regRdEn, charge_inhibit_pin, boost_request_pin, limit_reset_pin;
    logic chargeActive, faultEvent, statOut, statOe, chargeEnable, vbusHighZ, boostMode;
    logic [7:0] regAddr, regWrData, regRdData, safetyLimit;
    logic [1:0] inputLimitCode;
    int num_errors;
    int total_checks;

    cpc_charger_pin_ctl #(.PULSE_CYC(PULSE)) uut (
        .mclk(mclk), .rstn(rstn), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .charge_inhibit_pin(charge_inhibit_pin),
        .boost_request_pin(boost_request_pin), .limit_reset_pin(limit_reset_pin),
        .chargeActive(chargeActive), .faultEvent(faultEvent), .statOut(statOut),
        .statOe(statOe), .chargeEnable(chargeEnable), .vbusHighZ(vbusHighZ),
        .boostMode(boostMode), .inputLimitCode(inputLimitCode), .safetyLimit(safetyLimit));
    cpc_host_model host (.mclk(mclk), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData));

    // 20 MHz clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Counts low cycles on the status pin after one fault edge
    task automatic t_fault(input logic on);
        int n;
        n = 0;
        faultEvent = 1'b1;
        repeat (PULSE + 6) begin
            cyc(1);
            faultEvent = 1'b0;
            if (statOe === 1'b1) n++;
        end
        chk(8'(n), on ? 8'(PULSE) : 8'h00);
    endtask

    task automatic t_start;
        logic [7:0] d;
        logic [7:0] e;
        host.rd(CPC_OFS_CONTROL, d);
        chk(d, CPC_CONTROL_RST);
        host.rd(8'h20, d);
        chk(d, 8'h00);
        chk(safetyLimit, CPC_SAFETY_LIMIT_RST);
        // Fresh from reset: startup mode, charging allowed, nothing else set
        e = 8'h00;
        e[CPC_STS_STARTUP] = 1'b1;
        e[CPC_STS_CHARGE_EN] = 1'b1;
        host.rd(CPC_OFS_STATUS, d);
        chk(d, e);
        boost_request_pin = 1'b1;
        cyc(2);
        chk({5'h00, boostMode, inputLimitCode}, {6'h00, CPC_ILIM_500MA});
        boost_request_pin = 1'b0;
        cyc(2);
        chk({5'h00, boostMode, inputLimitCode}, {6'h00, CPC_ILIM_100MA});
    endtask

    task automatic t_pins;
        charge_inhibit_pin = 1'b1;
        cyc(2);
        chk({6'h00, chargeEnable, vbusHighZ}, 8'h01);
        charge_inhibit_pin = 1'b0;
        chargeActive = 1'b1;
        cyc(2);
        chk({5'h00, chargeEnable, statOe, statOut}, 8'h06);
        chargeActive = 1'b0;
        cyc(2);
        chk({7'h00, statOe}, 8'h00);
        t_fault(1'b1);
    endtask

    task automatic t_ctrl;
        host.wr(CPC_OFS_CONTROL, 8'h03);
        boost_request_pin = 1'b1;
        cyc(2);
        chk({7'h00, boostMode}, 8'h01);
        host.wr(CPC_OFS_CONTROL, 8'h08);
        chargeActive = 1'b1;
        cyc(3);
        chk({5'h00, boostMode, inputLimitCode}, 8'h01);
        chk({7'h00, statOe}, 8'h00);
        chargeActive = 1'b0;
        t_fault(1'b0);
        host.wr(CPC_OFS_CONTROL, 8'h03);
    endtask

    task automatic t_safety;
        logic [7:0] d;
        limit_reset_pin = 1'b0;
        host.wr(CPC_OFS_SAFETY_LIMIT, 8'h5a);
        cyc(1);
        chk(safetyLimit, CPC_SAFETY_LIMIT_RST);
        limit_reset_pin = 1'b1;
        host.wr(CPC_OFS_SAFETY_LIMIT, 8'ha5);
        host.rd(CPC_OFS_SAFETY_LIMIT, d);
        chk(d, 8'ha5);
        host.wr(CPC_OFS_STATUS, 8'h00);
        host.wr(CPC_OFS_SAFETY_LIMIT, 8'h3c);
        cyc(1);
        chk(safetyLimit, 8'ha5);
        host.rd(CPC_OFS_STATUS, d);
        chk(8'(d[CPC_STS_LOCKED]), 8'h01);
        limit_reset_pin = 1'b0;
        cyc(2);
        chk(safetyLimit, CPC_SAFETY_LIMIT_RST);
    endtask

    // Pin low unlocks; a reset mid-run restores defaults, unlocks and re-enters startup
    task automatic t_reset;
        logic [7:0] d;
        limit_reset_pin = 1'b1;
        host.wr(CPC_OFS_SAFETY_LIMIT, 8'h3c);
        cyc(1);
        chk(safetyLimit, 8'h3c);
        host.wr(CPC_OFS_CONTROL, 8'h1b);
        host.wr(CPC_OFS_SAFETY_LIMIT, 8'h77);
        cyc(1);
        chk(safetyLimit, 8'h3c);
        rstn = 1'b0;
        cyc(2);
        chk(safetyLimit, CPC_SAFETY_LIMIT_RST);
        rstn = 1'b1;
        cyc(2);
        host.rd(CPC_OFS_CONTROL, d);
        chk(d, CPC_CONTROL_RST);
        chk({5'h00, boostMode, inputLimitCode}, {6'h00, CPC_ILIM_500MA});
        host.wr(CPC_OFS_SAFETY_LIMIT, 8'h96);
        cyc(1);
        chk(safetyLimit, 8'h96);
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        num_errors = 0;
        total_checks = 0;
        rstn = 1'b0;
        charge_inhibit_pin = 1'b0;
        boost_request_pin = 1'b0;
        limit_reset_pin = 1'b1;
        chargeActive = 1'b0;
        faultEvent = 1'b0;
        cyc(5);
        rstn = 1'b1;
        cyc(2);
        t_start();
        t_pins();
        t_ctrl();
        t_safety();
        t_reset();
        give_verdict();
    end

    // Watchdog, far beyond the hundred or so cycles the run needs
    initial begin
        #(50 * 3000);
        num_errors++;
        give_verdict();
    end
endmodule // testbench
